// >>> hdl/cfgp_pkg.sv
package cfgp_pkg;

    localparam int          NUM_CFG   = 8;
    localparam int          CFG_BITS  = 8;
    localparam int          NUM_BLK   = 5;
    localparam int          LANE_LO   = 0;
    localparam logic [23:0] CFG_BASE  = 24'h300000;
    localparam logic [23:0] CFG_TOP   = 24'h3000FF;
    localparam logic [23:0] CFG_SPACE_TOP = 24'h3FFFFF;

    // Register indices; the bus byte address is four times (index - CFG_BASE).
    localparam logic [23:0] IDX_RESET_PIN_TIMER_MUX_CONFIG       = 24'h300005;
    localparam logic [23:0] IDX_DEBUG_INSTR_STACK_CONFIG         = 24'h300006;
    localparam logic [23:0] IDX_BLOCK_CODE_PROTECT               = 24'h300008;
    localparam logic [23:0] IDX_BOOT_EEPROM_CODE_PROTECT         = 24'h300009;
    localparam logic [23:0] IDX_BLOCK_WRITE_PROTECT              = 24'h30000A;
    localparam logic [23:0] IDX_BOOT_EEPROM_CONFIG_WRITE_PROTECT = 24'h30000B;
    localparam logic [23:0] IDX_BLOCK_TABLE_READ_PROTECT         = 24'h30000C;
    localparam logic [23:0] IDX_BOOT_TABLE_READ_PROTECT          = 24'h30000D;

    localparam logic [23:0] CFG_INDEX [NUM_CFG] = '{
        IDX_RESET_PIN_TIMER_MUX_CONFIG, IDX_DEBUG_INSTR_STACK_CONFIG,
        IDX_BLOCK_CODE_PROTECT, IDX_BOOT_EEPROM_CODE_PROTECT,
        IDX_BLOCK_WRITE_PROTECT, IDX_BOOT_EEPROM_CONFIG_WRITE_PROTECT,
        IDX_BLOCK_TABLE_READ_PROTECT, IDX_BOOT_TABLE_READ_PROTECT};

    // Slot numbers inside the storage array.
    localparam int SLOT_PIN = 0;
    localparam int SLOT_DBG = 1;
    localparam int SLOT_CP  = 2;
    localparam int SLOT_CPH = 3;
    localparam int SLOT_WR  = 4;
    localparam int SLOT_WRH = 5;
    localparam int SLOT_RP  = 6;
    localparam int SLOT_RPH = 7;

    localparam logic [7:0] CFG_UNPROG [NUM_CFG] = '{
        8'h83, 8'h85, 8'h0F, 8'hC0, 8'h0F, 8'hE0, 8'h0F, 8'h40};
    localparam logic [7:0] CFG_IMPL   [NUM_CFG] = '{
        8'h87, 8'hC5, 8'h0F, 8'hC0, 8'h0F, 8'hE0, 8'h0F, 8'h40};
    // Bits that a write may only clear.
    localparam logic [7:0] CFG_CLEAR  [NUM_CFG] = '{
        8'h00, 8'h00, 8'h0F, 8'hC0, 8'h0F, 8'hC0, 8'h0F, 8'h40};
    localparam logic [7:0] CFG_CONFIG_WRITE_PROTECT_MASK = 8'h20;

    // Bit positions.
    localparam int BIT_RESET_PIN_ENABLE     = 7;
    localparam int BIT_SECONDARY_TIMER_LP   = 2;
    localparam int BIT_PORT_ANALOG_DEFAULT  = 1;
    localparam int BIT_CAPCOMP_PIN_MUX      = 0;
    localparam int BIT_DEBUGGER_OFF         = 7;
    localparam int BIT_EXTENDED_INSTR       = 6;
    localparam int BIT_LOW_VOLTAGE_PROGRAM  = 2;
    localparam int BIT_STACK_ERROR_RESET    = 0;
    localparam int BIT_EEPROM_PROTECT       = 7;
    localparam int BIT_BOOT_PROTECT         = 6;
    localparam int BIT_CONFIG_WRITE_PROTECT = 5;

    // Program memory map; block numbers 0..3 are the main blocks, 4 is boot.
    localparam logic [2:0]  BLK_BOOT = 3'h4;
    localparam logic [2:0]  BLK_NONE = 3'h5;
    localparam logic [23:0] BOOT_HI  = 24'h0007FF;
    localparam logic [23:0] BLK_HI [4] = '{24'h001FFF, 24'h003FFF, 24'h005FFF, 24'h007FFF};

    typedef enum logic [1:0] {BUS_IDLE, BUS_WRITING, BUS_ACK} cfgp_bus_state_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       eeprom;
        logic [23:0] addr;
        logic [23:0] pc;
        logic [7:0] data;
    } cfgp_tbl_req_t;

    typedef struct packed {
        logic       done;
        logic       allowed;
        logic [7:0] data;
    } cfgp_tbl_rsp_t;

    typedef struct packed {
        logic       resetPinEnable;
        logic       secondaryTimerLowPower;
        logic       portAnalogDefault;
        logic       capcompOnPortC;
        logic       debuggerActive;
        logic       extendedInstrEnable;
        logic       lowVoltageProgramEnable;
        logic       stackErrorResetEnable;
        logic [4:0] codeProtect;
        logic       eepromCodeProtect;
        logic [4:0] writeProtect;
        logic       eepromWriteProtect;
        logic       configWriteProtect;
        logic [4:0] readProtect;
    } cfgp_decode_t;

endpackage

// >>> hdl/cfgp_config_protect.sv
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps

// Functional notes
// - Pin enable bit selects external reset or input.
// - Timer low-power bit picks oscillator power mode.
// - Analog default sets port B reset configuration.
// - Mux bit routes capture/compare to port pin.
// - Debugger enabled when bit clear, dedicating pins.
// - Extended instruction bit enables indexed addressing.
// - Low-voltage bit enables single-supply programming entry.
// - Stack error bit makes stack faults reset.
// - Code-protect bits guard blocks zero to three.
// - Boot code-protect bit guards boot block.
// - EEPROM code-protect bit guards data EEPROM.
// - Write-protect bits block writes per block.
// - Boot write-protect bit blocks boot writes.
// - EEPROM write-protect top bit blocks EEPROM writes.
// - Config write-protect blocks configuration range writes.
// - Config write-protect changeable only in programming mode.
// - Read-protect bits stop cross-block table reads.
// - Boot read-protect bit stops cross-block boot reads.
// - Unimplemented bits always read as zero.
// - Protection bits unprogrammed one, writes only clear.
// - Config space via table access, byte long writes.
module cfgp_config_protect #(
    parameter int LONG_WRITE_CYCLES = 16
) (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rstn,
    // Avalon-MM register slave
    input  wire logic [9:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    // Device mode and pins
    input  wire logic                   progMode,
    input  wire logic                   extResetPinN,
    input  wire logic                   stackFault,
    // Table read and write checking
    input  wire cfgp_pkg::cfgp_tbl_req_t tblReq,
    output cfgp_pkg::cfgp_tbl_rsp_t     tblRsp,
    // Decoded configuration
    output cfgp_pkg::cfgp_decode_t      decoded,
    output logic                        extResetReq,
    output logic                        portEInputThree,
    output logic                        stackResetReq,
    output logic      [4:0]             analogConfigReset,
    output logic                        capcompPortCSel,
    output logic                        debugPinsDedicated,
    output logic                        lowVoltageProgramEntry
);

    localparam int CW = $clog2(LONG_WRITE_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////////////////
    // Storage: the non-volatile bytes and the copy latched at reset.

    logic [7:0]                 nvCfg  [cfgp_pkg::NUM_CFG];
    logic [7:0]                 actCfg [cfgp_pkg::NUM_CFG];
    logic                       loadPending;
    cfgp_pkg::cfgp_bus_state_t  busState;
    logic [CW-1:0]              writeCount;
    logic [2:0]                 wrSlot;
    logic [7:0]                 wrByte;

    ////////////////////////////////////////////////////////////////////////////////////
    // Register decode.

    function automatic logic [2:0] slotOf(input logic [cfgp_pkg::NUM_CFG-1:0] hits);
        logic [2:0] s;
        s = 3'h0;
        for (int i = 0; i < cfgp_pkg::NUM_CFG; i++) begin
            if (hits[i]) begin
                s = 3'(i);
            end
        end
        return s;
    endfunction

    wire logic [23:0]                   busIndex = cfgp_pkg::CFG_BASE + 24'(avs_address[9:2]);
    wire logic [cfgp_pkg::NUM_CFG-1:0]  busHit;
    wire logic [cfgp_pkg::NUM_CFG-1:0]  slotIsWrtc;

    genvar g;
    generate
        for (g = 0; g < cfgp_pkg::NUM_CFG; g++) begin : g_hit
            assign busHit[g] = (busIndex == cfgp_pkg::CFG_INDEX[g]);
            assign slotIsWrtc[g] = (g == cfgp_pkg::SLOT_WRH);
        end
    endgenerate

    wire logic       busMapped = |busHit;
    wire logic [2:0] busSlot   = slotOf(busHit);
    wire logic       selWrtc   = slotIsWrtc[busSlot];
    wire logic [7:0] curByte   = nvCfg[busSlot];
    wire logic [7:0] implMask  = cfgp_pkg::CFG_IMPL[busSlot];

    // The configuration write-protect bit is read-only outside programming mode,
    // and in programming mode it joins the clear-only bits.
    wire logic [7:0] wrtcBits  = selWrtc ? cfgp_pkg::CFG_CONFIG_WRITE_PROTECT_MASK : 8'h00;
    wire logic [7:0] keepMask  = progMode ? 8'h00 : wrtcBits;
    wire logic [7:0] clrMask   = cfgp_pkg::CFG_CLEAR[busSlot] | (progMode ? wrtcBits : 8'h00);
    wire logic [7:0] progMask  = implMask & ~clrMask & ~keepMask;
    wire logic [7:0] wdByte    = avs_writedata[7:0];
    wire logic [7:0] newByte   = ((wdByte & progMask)
                                | (curByte & wdByte & clrMask)
                                | (curByte & keepMask)) & implMask;

    // Configuration writes are refused while the write-protect bit is clear,
    // except from the external programmer.
    wire logic cfgWriteOk = busMapped & avs_byteenable[cfgp_pkg::LANE_LO]
                          & (progMode | ~decoded.configWriteProtect);

    wire logic [31:0] busReadWord = busMapped ? {24'h000000, curByte & implMask}
                                              : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////////////
    // Decoded view of the latched bytes.

    cfgp_pkg::cfgp_decode_t next_decoded;

    assign next_decoded.resetPinEnable =
        actCfg[cfgp_pkg::SLOT_PIN][cfgp_pkg::BIT_RESET_PIN_ENABLE];
    assign next_decoded.secondaryTimerLowPower =
        actCfg[cfgp_pkg::SLOT_PIN][cfgp_pkg::BIT_SECONDARY_TIMER_LP];
    assign next_decoded.portAnalogDefault =
        actCfg[cfgp_pkg::SLOT_PIN][cfgp_pkg::BIT_PORT_ANALOG_DEFAULT];
    assign next_decoded.capcompOnPortC =
        actCfg[cfgp_pkg::SLOT_PIN][cfgp_pkg::BIT_CAPCOMP_PIN_MUX];
    assign next_decoded.debuggerActive =
        ~actCfg[cfgp_pkg::SLOT_DBG][cfgp_pkg::BIT_DEBUGGER_OFF];
    assign next_decoded.extendedInstrEnable =
        actCfg[cfgp_pkg::SLOT_DBG][cfgp_pkg::BIT_EXTENDED_INSTR];
    assign next_decoded.lowVoltageProgramEnable =
        actCfg[cfgp_pkg::SLOT_DBG][cfgp_pkg::BIT_LOW_VOLTAGE_PROGRAM];
    assign next_decoded.stackErrorResetEnable =
        actCfg[cfgp_pkg::SLOT_DBG][cfgp_pkg::BIT_STACK_ERROR_RESET];
    assign next_decoded.codeProtect = {
        ~actCfg[cfgp_pkg::SLOT_CPH][cfgp_pkg::BIT_BOOT_PROTECT],
        ~actCfg[cfgp_pkg::SLOT_CP][3:0]};
    assign next_decoded.eepromCodeProtect =
        ~actCfg[cfgp_pkg::SLOT_CPH][cfgp_pkg::BIT_EEPROM_PROTECT];
    assign next_decoded.writeProtect = {
        ~actCfg[cfgp_pkg::SLOT_WRH][cfgp_pkg::BIT_BOOT_PROTECT],
        ~actCfg[cfgp_pkg::SLOT_WR][3:0]};
    assign next_decoded.eepromWriteProtect =
        ~actCfg[cfgp_pkg::SLOT_WRH][cfgp_pkg::BIT_EEPROM_PROTECT];
    assign next_decoded.configWriteProtect =
        ~actCfg[cfgp_pkg::SLOT_WRH][cfgp_pkg::BIT_CONFIG_WRITE_PROTECT];
    assign next_decoded.readProtect = {
        ~actCfg[cfgp_pkg::SLOT_RPH][cfgp_pkg::BIT_BOOT_PROTECT],
        ~actCfg[cfgp_pkg::SLOT_RP][3:0]};

    ////////////////////////////////////////////////////////////////////////////////////
    // Table access checking.

    function automatic logic [2:0] blockOf(input logic [23:0] a);
        logic [2:0] b;
        b = cfgp_pkg::BLK_NONE;
        for (int i = 3; i >= 0; i--) begin
            if (a <= cfgp_pkg::BLK_HI[i]) begin
                b = 3'(i);
            end
        end
        if (a <= cfgp_pkg::BOOT_HI) begin
            b = cfgp_pkg::BLK_BOOT;
        end
        return b;
    endfunction

    wire logic [2:0] tgtBlk   = blockOf(tblReq.addr);
    wire logic [2:0] srcBlk   = blockOf(tblReq.pc);
    wire logic       tgtValid = (tgtBlk != cfgp_pkg::BLK_NONE);
    wire logic       inCfgRng = (tblReq.addr >= cfgp_pkg::CFG_BASE)
                              & (tblReq.addr <= cfgp_pkg::CFG_TOP);

    // A read from another block is stopped by the read-protect bit of the target.
    wire logic crossReadBlk = tgtValid & (tgtBlk != srcBlk)
                            & decoded.readProtect[tgtBlk];
    // The external programmer cannot read out code-protected memory.
    wire logic progReadBlk  = progMode & (tblReq.eeprom ? decoded.eepromCodeProtect
                            : (tgtValid & decoded.codeProtect[tgtBlk]));
    wire logic readBlocked  = ~tblReq.eeprom & crossReadBlk | progReadBlk;

    wire logic writeBlocked = tblReq.eeprom ? decoded.eepromWriteProtect
                            : inCfgRng ? (~progMode & decoded.configWriteProtect)
                            : (tgtValid & decoded.writeProtect[tgtBlk]);

    wire logic       tblAllowed = tblReq.write ? ~writeBlocked : ~readBlocked;
    // Blocked reads give zero; blocked writes are dropped silently.
    wire logic [7:0] tblData    = (tblReq.write | readBlocked) ? 8'h00 : tblReq.data;

    ////////////////////////////////////////////////////////////////////////////////////
    // Reset-time latch of the configuration.

    // A stack fault or pin reset that resets the device also reloads the copy.
    wire logic next_stackReset = stackFault & decoded.stackErrorResetEnable;
    wire logic next_extReset   = decoded.resetPinEnable & ~extResetPinN;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            loadPending <= 1'b1;
            for (int i = 0; i < cfgp_pkg::NUM_CFG; i++) begin
                actCfg[i] <= cfgp_pkg::CFG_UNPROG[i];
            end
        end else if (stackResetReq | extResetReq) begin
            loadPending <= 1'b1;
        end else if (loadPending) begin
            loadPending <= 1'b0;
            actCfg      <= nvCfg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Non-volatile byte store; each byte is written alone after the long write.

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < cfgp_pkg::NUM_CFG; i++) begin
                nvCfg[i] <= cfgp_pkg::CFG_UNPROG[i];
            end
        end else if (busState == cfgp_pkg::BUS_WRITING && writeCount == '0) begin
            nvCfg[wrSlot] <= wrByte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave with a self-timed long write.

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busState        <= cfgp_pkg::BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
            writeCount      <= '0;
            wrSlot          <= 3'h0;
            wrByte          <= 8'h00;
        end else begin
            case (busState)
                cfgp_pkg::BUS_IDLE: begin
                    if (avs_read) begin
                        avs_readdata    <= busReadWord;
                        avs_waitrequest <= 1'b0;
                        busState        <= cfgp_pkg::BUS_ACK;
                    end else if (avs_write && cfgWriteOk) begin
                        wrSlot     <= busSlot;
                        wrByte     <= newByte;
                        writeCount <= CW'(LONG_WRITE_CYCLES - 1);
                        busState   <= cfgp_pkg::BUS_WRITING;
                    end else if (avs_write) begin
                        avs_waitrequest <= 1'b0;
                        busState        <= cfgp_pkg::BUS_ACK;
                    end
                end
                cfgp_pkg::BUS_WRITING: begin
                    if (writeCount == '0) begin
                        avs_waitrequest <= 1'b0;
                        busState        <= cfgp_pkg::BUS_ACK;
                    end else begin
                        writeCount <= writeCount - CW'(1);
                    end
                end
                cfgp_pkg::BUS_ACK: begin
                    avs_waitrequest <= 1'b1;
                    busState        <= cfgp_pkg::BUS_IDLE;
                end
                default: begin
                    avs_waitrequest <= 1'b1;
                    busState        <= cfgp_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Registered outputs.

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            decoded                <= '0;
            extResetReq            <= 1'b0;
            portEInputThree        <= 1'b0;
            stackResetReq          <= 1'b0;
            analogConfigReset      <= 5'h00;
            capcompPortCSel        <= 1'b0;
            debugPinsDedicated     <= 1'b0;
            lowVoltageProgramEntry <= 1'b0;
            tblRsp                 <= '0;
        end else begin
            decoded                <= next_decoded;
            extResetReq            <= next_extReset;
            portEInputThree        <= ~decoded.resetPinEnable & extResetPinN;
            stackResetReq          <= next_stackReset;
            analogConfigReset      <= {5{decoded.portAnalogDefault}};
            capcompPortCSel        <= decoded.capcompOnPortC;
            debugPinsDedicated     <= decoded.debuggerActive;
            lowVoltageProgramEntry <= decoded.lowVoltageProgramEnable;
            tblRsp.done            <= tblReq.valid;
            tblRsp.allowed         <= tblReq.valid & tblAllowed;
            tblRsp.data            <= tblReq.valid ? tblData : 8'h00;
        end
    end

endmodule

// >>> dv/cfgp_config_protect_asserts.sv
`timescale 1ns/1ps

module cfgp_config_protect_asserts #(
    parameter int LONG_WRITE_CYCLES = 16
) (
    // Clock, reset and bus
    input wire logic                    sys_clk,
    input wire logic                    rstn,
    input wire logic                    avs_read,
    input wire logic                    avs_waitrequest,
    // Pins, table path and decode
    input wire logic                    extResetPinN,
    input wire logic                    stackFault,
    input wire cfgp_pkg::cfgp_tbl_req_t tblReq,
    input wire cfgp_pkg::cfgp_tbl_rsp_t tblRsp,
    input wire cfgp_pkg::cfgp_decode_t  decoded,
    input wire logic                    extResetReq,
    input wire logic                    portEInputThree,
    input wire logic                    stackResetReq,
    input wire logic [4:0]              analogConfigReset,
    input wire logic                    debugPinsDedicated
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_ack;
        ##1 !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence s_boot_wr;
        tblReq.valid && tblReq.write && !tblReq.eeprom && tblReq.addr <= 24'h0007FF
            && decoded.writeProtect[4];
    endsequence
    a_read_answer:
        assert property ($rose(avs_read) |-> s_ack) else $error("read answer late");
    a_ext_reset_cause:
        assert property (extResetReq == $past(!extResetPinN && decoded.resetPinEnable))
        else $error("external reset request wrong");
    a_pin_as_input:
        assert property (decoded.resetPinEnable && $past(decoded.resetPinEnable)
            |-> !portEInputThree) else $error("pin input live while reset pin on");
    a_stack_reset:
        assert property (stackResetReq == $past(stackFault && decoded.stackErrorResetEnable))
        else $error("stack reset request wrong");
    a_analog_default:
        assert property (analogConfigReset == {5{$past(decoded.portAnalogDefault)}})
        else $error("analog default wrong");
    a_debug_pins:
        assert property (debugPinsDedicated == $past(decoded.debuggerActive))
        else $error("debug pin dedication wrong");
    a_boot_write:
        assert property (s_boot_wr |=> tblRsp.done && !tblRsp.allowed)
        else $error("boot write not blocked");
    a_blocked_zero:
        assert property (tblRsp.done && !tblRsp.allowed |-> tblRsp.data == 8'h00)
        else $error("blocked access returned data");
endmodule

////////////////////////////////////////////////////////////////////////////////
bind cfgp_config_protect cfgp_config_protect_asserts
    #(.LONG_WRITE_CYCLES(LONG_WRITE_CYCLES)) chk_u (
    .sys_clk(sys_clk), .rstn(rstn), .avs_read(avs_read), .avs_waitrequest(avs_waitrequest),
    .extResetPinN(extResetPinN), .stackFault(stackFault), .tblReq(tblReq), .tblRsp(tblRsp),
    .decoded(decoded), .extResetReq(extResetReq), .portEInputThree(portEInputThree),
    .stackResetReq(stackResetReq), .analogConfigReset(analogConfigReset),
    .debugPinsDedicated(debugPinsDedicated));

// >>> dv/cfgp_tbl_source.sv
`timescale 1ns/1ps

module cfgp_tbl_source (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rstn,
    // Command from the bench
    input  wire logic                    go,
    input  wire cfgp_pkg::cfgp_tbl_req_t cmd,
    // Request toward the block
    output cfgp_pkg::cfgp_tbl_req_t      tblReq
);
    // Between requests valid is held low and every other field flips each cycle so stale values are never trusted.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tblReq <= '0;
        end else if (go) begin
            tblReq <= cmd;
        end else begin
            tblReq <= {1'b0, ~tblReq[$bits(tblReq)-2:0]};
        end
    end
endmodule

// >>> dv/cfgp_config_protect_tb.sv
`timescale 1ns/1ps

module cfgp_config_protect_tb;
    logic                    sys_clk, rstn, avs_read, avs_write, avs_waitrequest, progMode;
    logic                    extResetPinN, stackFault, go, extResetReq, portEInputThree;
    logic                    stackResetReq, capcompPortCSel, debugPinsDedicated;
    logic                    lowVoltageProgramEntry;
    logic [9:0]              avs_address;
    logic [31:0]             avs_writedata, avs_readdata;
    logic [3:0]              avs_byteenable;
    logic [4:0]              analogConfigReset;
    logic [7:0]              rnd, rPin, rDbg;
    cfgp_pkg::cfgp_tbl_req_t cmd, tblReq;
    cfgp_pkg::cfgp_tbl_rsp_t tblRsp;
    cfgp_pkg::cfgp_decode_t  decoded;
    logic [31:0]             expRd[$];
    logic [8:0]              expTbl[$];
    int                      err_count = 0;
    int                      n_compared = 0;

    cfgp_config_protect #(.LONG_WRITE_CYCLES(2)) dut_u (
        .sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .progMode(progMode),
        .extResetPinN(extResetPinN), .stackFault(stackFault), .tblReq(tblReq),
        .tblRsp(tblRsp), .decoded(decoded), .extResetReq(extResetReq),
        .portEInputThree(portEInputThree), .stackResetReq(stackResetReq),
        .analogConfigReset(analogConfigReset), .capcompPortCSel(capcompPortCSel),
        .debugPinsDedicated(debugPinsDedicated),
        .lowVoltageProgramEntry(lowVoltageProgramEntry));
    cfgp_tbl_source src_u (.sys_clk(sys_clk), .rstn(rstn), .go(go), .cmd(cmd), .tblReq(tblReq));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= wr;
        avs_read <= ~wr;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            err_count++;
            complete_run();
        end
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        expRd.push_back({24'h000000, e});
        bus(1'b0, a, 8'h00);
    endtask

    task automatic tbl(input logic wr, ee, input logic [23:0] a, pc, input logic ok);
        @(posedge sys_clk);
        rnd = 8'($urandom);
        cmd <= '{1'b1, wr, ee, a, pc, rnd};
        go <= 1'b1;
        expTbl.push_back({ok, (ok && !wr) ? rnd : 8'h00});
    endtask

    task automatic reload();
        @(posedge sys_clk);
        stackFault <= 1'b1;
        @(posedge sys_clk);
        stackFault <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask

    // Results are compared in arrival order against the notes left by the drivers.
    always @(posedge sys_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            check(avs_readdata, expRd.pop_front());
        end
        if (tblRsp.done === 1'b1) begin
            check({23'h000000, tblRsp.allowed, tblRsp.data}, {23'h000000, expTbl.pop_front()});
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        {avs_read, avs_write, progMode, stackFault, go} = 5'h00;
        avs_address = 10'h000;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
        extResetPinN = 1'b1;
        cmd = '0;
        void'($urandom(71));
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(10'(cfgp_pkg::CFG_INDEX[i] << 2), cfgp_pkg::CFG_UNPROG[i]);
        end
        rd(10'h3FC, 8'h00);
        check(32'({analogConfigReset, capcompPortCSel, debugPinsDedicated, lowVoltageProgramEntry,
            decoded.extendedInstrEnable, decoded.secondaryTimerLowPower, extResetReq,
            portEInputThree}), 32'h00000FD0);
        rPin = 8'($urandom) | 8'h80;
        rDbg = 8'($urandom) | 8'h01;
        bus(1'b1, 10'h014, rPin);
        bus(1'b1, 10'h018, rDbg);
        rd(10'h014, rPin & 8'h87);
        rd(10'h018, rDbg & 8'hC5);
        bus(1'b1, 10'h020, 8'h0C);
        bus(1'b1, 10'h020, 8'hFF);
        rd(10'h020, 8'h0C);
        bus(1'b1, 10'h028, 8'h0E);
        bus(1'b1, 10'h030, 8'h0D);
        bus(1'b1, 10'h02C, 8'h00);
        rd(10'h02C, 8'h20);
        reload();
        check(32'({decoded.codeProtect, decoded.writeProtect, decoded.readProtect,
            decoded.eepromWriteProtect, decoded.configWriteProtect}), 32'h0000388A);
        check(32'({decoded.secondaryTimerLowPower, decoded.extendedInstrEnable, analogConfigReset,
            debugPinsDedicated, capcompPortCSel}),
            32'({rPin[2], rDbg[6], {5{rPin[1]}}, ~rDbg[7], rPin[0]}));
        tbl(1'b1, 1'b0, 24'h000100, 24'h001000, 1'b0);
        tbl(1'b1, 1'b0, 24'h000900, 24'h002000, 1'b0);
        tbl(1'b1, 1'b0, 24'h002100, 24'h000900, 1'b1);
        tbl(1'b1, 1'b1, 24'h000010, 24'h000900, 1'b0);
        tbl(1'b0, 1'b0, 24'h002100, 24'h000900, 1'b0);
        tbl(1'b0, 1'b0, 24'h002200, 24'h002000, 1'b1);
        tbl(1'b0, 1'b0, 24'h000100, 24'h000900, 1'b1);
        tbl(1'b1, 1'b0, 24'h300005, 24'h000900, 1'b1);
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (3) @(posedge sys_clk);
        progMode <= 1'b1;
        tbl(1'b0, 1'b0, 24'h000900, 24'h000A00, 1'b0);
        tbl(1'b0, 1'b0, 24'h000100, 24'h000200, 1'b1);
        tbl(1'b0, 1'b1, 24'h000010, 24'h000200, 1'b1);
        @(posedge sys_clk);
        go <= 1'b0;
        bus(1'b1, 10'h02C, 8'h00);
        rd(10'h02C, 8'h00);
        progMode <= 1'b0;
        reload();
        bus(1'b1, 10'h014, 8'h00);
        rd(10'h014, rPin & 8'h87);
        extResetPinN <= 1'b0;
        @(posedge sys_clk);
        extResetPinN <= 1'b1;
        @(negedge sys_clk);
        check(32'(extResetReq), 32'h00000001);
        repeat (6) @(posedge sys_clk);
        check(32'(expRd.size() + expTbl.size()), 32'h00000000);
        complete_run();
    end
endmodule
